//--- pin_logic_cfg.svh
// Purpose: constants for the processor pin-state and reset logic
// Assumes: included by bare name; one 25 MHz clock stands in for the 2x input clock
// Notes: synchroniser vector bit positions, reset values and fixed codes
//
// Behaviour
// - output clock is half the input clock rate, 50% duty, toggling every cycle
// - reset request aborts bus cycle, initialises state, defines pins, asserts reset indication
// - on reset release realign output clock phase, then fetch from 0FFF0H
// - reset indication stays asserted exactly while reset request is asserted
// - test/busy pin sampled in reset selects coprocessor attach mode
// - in regular mode the wait instruction stalls until the test pin reads low
// - non-maskable interrupt edge is latched and serviced as type 2
// - address phase drives address on shared bus, data phase moves 8 or 16 bits
// - shared bus floats in hold and reset, retains its value in powerdown
// - each output has a defined state in hold, reset, idle and powerdown
// - output clock and oscillator drive stay active in hold, reset, powerdown
// - reset indication low in hold and powerdown, high in reset
// - after powerdown wait on exit timer pin; pin weak-high hold, float reset, high powerdown
// - coprocessor mode turns three of four mid-range selects into handshake lines
`ifndef PIN_LOGIC_CFG_SVH
`define PIN_LOGIC_CFG_SVH

`define SYNC_W 7
`define SY_RST_N 0
`define SY_BUSY 1
`define SY_NMI 2
`define SY_HOLD 3
`define SY_UCS_N 4
`define SY_LCS_N 5
`define SY_PDT 6
`define SYNC_INIT 7'h70

`define RESET_FETCH_ADDR 20'h0FFF0
`define NMI_TYPE 8'h02
`define COPROC_MCS_MASK 4'hB
`define MCS_RESET 4'hF

`endif

//--- pin_logic_pkg.sv
// Purpose: types shared by the pin-state and reset logic
// Assumes: nothing beyond SystemVerilog packages
// Notes: per-pin tables give the state in reset, powerdown, hold and idle
package pin_logic_pkg;

	typedef enum logic [2:0] {
		MODE_RUN = 3'b000,
		MODE_IDLE = 3'b001,
		MODE_HOLD = 3'b010,
		MODE_PD = 3'b011,
		MODE_RESET = 3'b100
	} op_mode_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ADDR = 2'b01,
		BUS_DATA = 2'b10,
		BUS_END = 2'b11
	} bus_state_t;

	typedef enum logic [2:0] {
		PS_HIGH = 3'b000,
		PS_LOW = 3'b001,
		PS_FLOAT = 3'b010,
		PS_ACTIVE = 3'b011,
		PS_RETAIN = 3'b100
	} pin_state_t;

	typedef struct packed {
		pin_state_t rst;
		pin_state_t pd;
		pin_state_t hold;
		pin_state_t idle;
	} pin_tbl_t;

	typedef struct packed {
		logic oe;
		logic [15:0] val;
	} pin_drv_t;

	// weak pull-up of the exit timer pin in hold is shown as float
	localparam pin_tbl_t AD_TBL = '{PS_FLOAT, PS_RETAIN, PS_FLOAT, PS_RETAIN};
	localparam pin_tbl_t ALE_TBL = '{PS_LOW, PS_LOW, PS_LOW, PS_LOW};
	localparam pin_tbl_t RSTIND_TBL = '{PS_HIGH, PS_LOW, PS_LOW, PS_ACTIVE};
	localparam pin_tbl_t PDT_TBL = '{PS_FLOAT, PS_HIGH, PS_FLOAT, PS_ACTIVE};

	typedef struct packed {
		logic clk_half;
		logic osc;
		logic in_reset;
		logic rst_ind;
		logic coproc;
		logic all_float_test_mode;
		op_mode_t mode;
		bus_state_t bus;
		logic [15:0] ad;
		logic [1:0] ad_oe;
		logic ale;
		logic wr;
		logic word;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic done;
		logic hlda;
		logic pd;
		logic pd_exit;
		logic pdt_oe;
		logic pdt;
		logic stall;
		logic restart;
		logic [19:0] fetch_addr;
		logic outs_en;
		logic [3:0] mcs_n;
		logic run;
	} pin_st_t;

	function automatic pin_drv_t pin_apply(pin_tbl_t t, op_mode_t m, logic [15:0] act,
		logic [15:0] last, logic act_oe);
		pin_state_t ps;
		pin_drv_t r;
		case (m)
			MODE_RESET: ps = t.rst;
			MODE_PD: ps = t.pd;
			MODE_HOLD: ps = t.hold;
			MODE_IDLE: ps = t.idle;
			default: ps = PS_ACTIVE;
		endcase
		case (ps)
			PS_HIGH: r = '{oe: 1'b1, val: 16'hFFFF};
			PS_LOW: r = '{oe: 1'b1, val: 16'h0000};
			PS_FLOAT: r = '{oe: 1'b0, val: last};
			PS_RETAIN: r = '{oe: act_oe, val: last};
			default: r = '{oe: act_oe, val: act};
		endcase
		return r;
	endfunction

endpackage

//--- pin_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to mclk_in
// Notes: stage one feeds only stage two; output moves when stages two and three agree
module pin_sync3 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	// pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_st_t;

	sync_st_t st_r;
	sync_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= {INIT, INIT, INIT, INIT};
		end else if (clk_en_in) begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.q;
endmodule

//--- nmi_latch.sv
// Purpose: catches a rising edge of the synchronised interrupt level
// Assumes: level_in already synchronised to mclk_in
// Notes: a new edge in the acknowledge cycle keeps the request pending
module nmi_latch (
	// clock and reset
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	// control
	input wire logic flush_in,
	input wire logic level_in,
	input wire logic ack_in,
	output logic pending_out,
	output logic edge_out
);
	typedef struct packed {
		logic prev;
		logic pend;
		logic edge_seen;
	} nmi_st_t;

	nmi_st_t st_r;
	nmi_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = level_in;
		st_nxt.edge_seen = level_in && !st_r.prev;
		if (flush_in) begin
			st_nxt.pend = 1'b0;
			st_nxt.edge_seen = 1'b0;
		end else begin
			if (ack_in) begin
				st_nxt.pend = 1'b0;
			end
			if (level_in && !st_r.prev) begin
				st_nxt.pend = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= '0;
		end else if (clk_en_in) begin
			st_r <= st_nxt;
		end
	end

	assign pending_out = st_r.pend;
	assign edge_out = st_r.edge_seen;
endmodule

//--- pin_state_ctrl.sv
// Purpose: pin-level control of the processor: clock, reset, straps, bus pins, pin states
// Assumes: mclk_in is the double-rate input clock; core-side signals are on mclk_in
// Notes: pin states follow reset, powerdown, hold, idle, regular in that order
`include "pin_logic_cfg.svh"

module pin_state_ctrl (
	// clock, reset, enable
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	// asynchronous pins
	input wire logic reset_request_n_in,
	input wire logic test_busy_in,
	input wire logic nmi_in,
	input wire logic hold_req_in,
	input wire logic upper_memory_select_n_in,
	input wire logic lower_memory_select_n_in,
	input wire logic powerdown_exit_timer_pin_in,
	input wire logic [15:0] shared_addr_data_bus_in,
	// core side
	input wire logic bus_req_in,
	input wire logic bus_write_in,
	input wire logic bus_word_in,
	input wire logic [15:0] bus_addr_in,
	input wire logic [15:0] bus_wdata_in,
	input wire logic wait_exec_in,
	input wire logic idle_req_in,
	input wire logic powerdown_req_in,
	input wire logic wake_in,
	input wire logic nmi_ack_in,
	input wire logic [3:0] mid_range_select_n_in,
	input wire logic [3:0] coproc_handshake_in,
	// pins out
	output logic half_rate_clock_out,
	output logic oscillator_drive_pin_out,
	output logic reset_indication_out,
	output logic ale_out,
	output logic [15:0] shared_addr_data_bus_out,
	output logic [1:0] shared_addr_data_bus_oe_out,
	output logic powerdown_exit_timer_pin_out,
	output logic powerdown_exit_timer_pin_oe_out,
	output logic [3:0] mid_range_select_n_out,
	output logic pins_drive_en_out,
	output logic hold_ack_out,
	// core side out
	output logic [15:0] bus_rdata_out,
	output logic bus_done_out,
	output logic stall_out,
	output logic nmi_pending_out,
	output logic [7:0] nmi_type_out,
	output logic restart_fetch_out,
	output logic [19:0] fetch_addr_out,
	output logic coproc_mode_out,
	output logic all_float_test_mode_out,
	output logic core_run_out
);
	import pin_logic_pkg::*;

	pin_st_t st_r;
	pin_st_t st_nxt;
	logic [`SYNC_W-1:0] sy;
	logic nmi_pend;
	logic nmi_edge;
	logic rst_w;
	logic release_w;
	logic accept_w;
	pin_drv_t ad_d;
	pin_drv_t ale_d;
	pin_drv_t ri_d;
	pin_drv_t pdt_d;

	pin_sync3 #(
		.WIDTH(`SYNC_W),
		.INIT(`SYNC_INIT)
	) u_sync (
		.mclk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.clk_en_in(clk_en_in),
		.pin_in({powerdown_exit_timer_pin_in, lower_memory_select_n_in,
			upper_memory_select_n_in, hold_req_in, nmi_in, test_busy_in,
			reset_request_n_in}),
		.sync_out(sy)
	);

	nmi_latch u_nmi (
		.mclk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.clk_en_in(clk_en_in),
		.flush_in(rst_w),
		.level_in(sy[`SY_NMI]),
		.ack_in(nmi_ack_in),
		.pending_out(nmi_pend),
		.edge_out(nmi_edge)
	);

	assign rst_w = !sy[`SY_RST_N];
	assign release_w = st_r.in_reset && !rst_w;
	assign accept_w = (st_r.bus == BUS_IDLE) && bus_req_in && !sy[`SY_HOLD] && !st_r.hlda
		&& !st_r.pd && !st_r.pd_exit && !idle_req_in && !rst_w;

	always_comb begin
		st_nxt = st_r;
		st_nxt.in_reset = rst_w;
		st_nxt.restart = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.osc = !st_r.osc;
		st_nxt.clk_half = release_w ? 1'b0 : !st_r.clk_half;
		st_nxt.rst_ind = rst_w;
		if (rst_w) begin
			// abort any cycle and sample the straps while reset is held
			st_nxt.bus = BUS_IDLE;
			st_nxt.ad_oe = 2'b00;
			st_nxt.ale = 1'b0;
			st_nxt.hlda = 1'b0;
			st_nxt.pd = 1'b0;
			st_nxt.pd_exit = 1'b0;
			st_nxt.stall = 1'b0;
			st_nxt.run = 1'b0;
			st_nxt.coproc = sy[`SY_BUSY];
			st_nxt.all_float_test_mode = !sy[`SY_UCS_N] && !sy[`SY_LCS_N];
		end else begin
			if (release_w) begin
				st_nxt.restart = 1'b1;
				st_nxt.fetch_addr = `RESET_FETCH_ADDR;
			end
			// same pin is test in regular mode and busy in coprocessor mode
			st_nxt.stall = wait_exec_in && sy[`SY_BUSY];
			if (sy[`SY_HOLD] && st_r.bus == BUS_IDLE && !st_r.pd && !st_r.pd_exit) begin
				st_nxt.hlda = 1'b1;
			end else if (!sy[`SY_HOLD]) begin
				st_nxt.hlda = 1'b0;
			end
			if (st_r.pd) begin
				if (wake_in) begin
					st_nxt.pd = 1'b0;
					st_nxt.pd_exit = 1'b1;
				end
			end else if (st_r.pd_exit) begin
				if (!sy[`SY_PDT]) begin
					st_nxt.pd_exit = 1'b0;
				end
			end else if (powerdown_req_in && st_r.bus == BUS_IDLE && !st_r.hlda && !accept_w) begin
				st_nxt.pd = 1'b1;
			end
			st_nxt.run = !st_nxt.pd && !st_nxt.pd_exit;
			case (st_r.bus)
				BUS_IDLE: begin
					if (accept_w) begin
						st_nxt.ad = bus_addr_in;
						st_nxt.ad_oe = 2'b11;
						st_nxt.ale = 1'b1;
						st_nxt.wr = bus_write_in;
						st_nxt.word = bus_word_in;
						st_nxt.wdata = bus_wdata_in;
						st_nxt.bus = BUS_ADDR;
					end
				end
				BUS_ADDR: begin
					st_nxt.ale = 1'b0;
					if (st_r.wr) begin
						st_nxt.ad = st_r.wdata;
						st_nxt.ad_oe = st_r.word ? 2'b11 : 2'b01;
					end else begin
						st_nxt.ad_oe = 2'b00;
					end
					st_nxt.bus = BUS_DATA;
				end
				BUS_DATA: begin
					if (!st_r.wr) begin
						st_nxt.rdata = st_r.word ? shared_addr_data_bus_in
							: {8'h00, shared_addr_data_bus_in[7:0]};
					end
					st_nxt.done = 1'b1;
					st_nxt.bus = BUS_END;
				end
				BUS_END: begin
					st_nxt.ad_oe = 2'b00;
					st_nxt.bus = BUS_IDLE;
				end
				default: begin
					st_nxt.bus = BUS_IDLE;
				end
			endcase
		end
		// pin state priority
		if (rst_w) begin
			st_nxt.mode = MODE_RESET;
		end else if (st_nxt.pd) begin
			st_nxt.mode = MODE_PD;
		end else if (st_nxt.hlda) begin
			st_nxt.mode = MODE_HOLD;
		end else if (idle_req_in) begin
			st_nxt.mode = MODE_IDLE;
		end else begin
			st_nxt.mode = MODE_RUN;
		end
		st_nxt.outs_en = !st_nxt.all_float_test_mode;
		st_nxt.mcs_n = st_nxt.coproc ? ((mid_range_select_n_in & ~`COPROC_MCS_MASK)
			| (coproc_handshake_in & `COPROC_MCS_MASK)) : mid_range_select_n_in;
		if (rst_w) begin
			st_nxt.mcs_n = `MCS_RESET;
		end
	end

	// per-pin states applied to the nominal values
	assign ad_d = pin_apply(AD_TBL, st_nxt.mode, st_nxt.ad, st_r.ad, |st_nxt.ad_oe);
	assign ale_d = pin_apply(ALE_TBL, st_nxt.mode, {15'h0000, st_nxt.ale}, {15'h0000, st_r.ale},
		1'b1);
	assign ri_d = pin_apply(RSTIND_TBL, st_nxt.mode, {15'h0000, st_nxt.rst_ind},
		{15'h0000, st_r.rst_ind}, 1'b1);
	assign pdt_d = pin_apply(PDT_TBL, st_nxt.mode, 16'h0000, {15'h0000, st_r.pdt}, 1'b0);

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_r <= '0;
			st_r.in_reset <= 1'b1;
			st_r.rst_ind <= 1'b1;
			st_r.mode <= MODE_RESET;
			st_r.mcs_n <= `MCS_RESET;
			st_r.outs_en <= 1'b1;
		end else if (clk_en_in) begin
			st_r <= st_nxt;
			st_r.ad <= ad_d.val;
			st_r.ad_oe <= (ad_d.oe && !st_nxt.all_float_test_mode) ? st_nxt.ad_oe : 2'b00;
			st_r.ale <= ale_d.val[0];
			st_r.rst_ind <= ri_d.val[0];
			st_r.pdt <= pdt_d.val[0];
			st_r.pdt_oe <= pdt_d.oe && !st_nxt.all_float_test_mode;
		end
	end

	assign half_rate_clock_out = st_r.clk_half;
	assign oscillator_drive_pin_out = st_r.osc;
	assign reset_indication_out = st_r.rst_ind;
	assign ale_out = st_r.ale;
	assign shared_addr_data_bus_out = st_r.ad;
	assign shared_addr_data_bus_oe_out = st_r.ad_oe;
	assign powerdown_exit_timer_pin_out = st_r.pdt;
	assign powerdown_exit_timer_pin_oe_out = st_r.pdt_oe;
	assign mid_range_select_n_out = st_r.mcs_n;
	assign pins_drive_en_out = st_r.outs_en;
	assign hold_ack_out = st_r.hlda;
	assign bus_rdata_out = st_r.rdata;
	assign bus_done_out = st_r.done;
	assign stall_out = st_r.stall;
	assign nmi_pending_out = nmi_pend;
	assign nmi_type_out = `NMI_TYPE;
	assign restart_fetch_out = st_r.restart;
	assign fetch_addr_out = st_r.fetch_addr;
	assign coproc_mode_out = st_r.coproc;
	assign all_float_test_mode_out = st_r.all_float_test_mode;
	assign core_run_out = st_r.run;

	property p_clk_toggle;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && !release_w) |=> (half_rate_clock_out != $past(half_rate_clock_out));
	endproperty
	a_clk_toggle: assert property (p_clk_toggle) else $error("output clock did not toggle");

	sequence s_restart;
		!half_rate_clock_out && restart_fetch_out && fetch_addr_out == 20'h0FFF0;
	endsequence
	property p_restart;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && release_w) |=> s_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart not aligned to reset vector");

	property p_abort;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && rst_w) |=> (shared_addr_data_bus_oe_out == 2'b00 && !ale_out
			&& reset_indication_out && !hold_ack_out);
	endproperty
	a_abort: assert property (p_abort) else $error("reset did not abort and define pins");

	property p_reset_indication_out;
		@(posedge mclk_in) disable iff (!arst_n_in)
		clk_en_in |=> (reset_indication_out == $past(rst_w));
	endproperty
	a_reset_indication_out: assert property (p_reset_indication_out) else $error("reset indication not tracking request");

	property p_strap;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && release_w) |-> (coproc_mode_out == $past(sy[`SY_BUSY]));
	endproperty
	a_strap: assert property (p_strap) else $error("coprocessor strap not taken in reset");

	property p_wait;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && !rst_w && wait_exec_in && sy[`SY_BUSY]) |=> stall_out;
	endproperty
	a_wait: assert property (p_wait) else $error("wait did not stall on test high");

	property p_nmi;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && nmi_edge && !rst_w) |-> (nmi_pending_out && nmi_type_out == 8'h02);
	endproperty
	a_nmi: assert property (p_nmi) else $error("interrupt edge not latched");

	sequence s_addr_phase;
		reset_indication_out || (ale_out && shared_addr_data_bus_oe_out == 2'b11
			&& shared_addr_data_bus_out == $past(bus_addr_in));
	endsequence
	property p_addr;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && accept_w && !idle_req_in) |=> s_addr_phase;
	endproperty
	a_addr: assert property (p_addr) else $error("address phase wrong");

	property p_float;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(hold_ack_out && !reset_indication_out && st_r.mode == MODE_HOLD)
			|-> shared_addr_data_bus_oe_out == 2'b00;
	endproperty
	a_float: assert property (p_float) else $error("shared bus driven in hold");

	property p_pd_retain;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && st_r.mode == MODE_PD && st_nxt.mode == MODE_PD)
			|=> $stable(shared_addr_data_bus_out) && powerdown_exit_timer_pin_oe_out == !st_r.all_float_test_mode;
	endproperty
	a_pd_retain: assert property (p_pd_retain) else $error("powerdown pin state wrong");

	property p_osc;
		@(posedge mclk_in) disable iff (!arst_n_in)
		clk_en_in |=> (oscillator_drive_pin_out != $past(oscillator_drive_pin_out));
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator drive stopped");

	property p_ri_low;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_r.mode == MODE_HOLD || st_r.mode == MODE_PD) |-> !reset_indication_out;
	endproperty
	a_ri_low: assert property (p_ri_low) else $error("reset indication high in hold");

	property p_mcs;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(clk_en_in && !rst_w && st_nxt.coproc)
			|=> mid_range_select_n_out[0] == $past(coproc_handshake_in[0]);
	endproperty
	a_mcs: assert property (p_mcs) else $error("handshake line not routed");
endmodule

//--- far_side_model.sv
// Purpose: far side of the pins: memory on the shared bus, coprocessor busy, timer capacitor
// Assumes: shares the one clock with the device
// Notes: a released bus line shows the inverse of its last level
module far_side_model #(
	parameter int PDT_DLY = 6
) (
	input wire logic mclk_in,
	input wire logic [15:0] ad_drv_in,
	input wire logic [1:0] ad_oe_in,
	input wire logic ale_in,
	input wire logic rst_ind_in,
	input wire logic strap_en_in,
	input wire logic busy_in,
	input wire logic pdt_drv_in,
	input wire logic pdt_oe_in,
	output logic [15:0] ad_out,
	output logic test_busy_out,
	output logic pdt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [int];
	logic [15:0] addr_r = 16'h0000;
	logic [15:0] rd_r = 16'h0000;
	logic [15:0] last_r = 16'h0000;
	logic ph_r = 1'b0;
	int cnt_r = 0;
	always @(posedge mclk_in) begin
		if (ale_in) begin
			addr_r <= ad_drv_in;
			rd_r <= mem.exists(ad_drv_in) ? mem[ad_drv_in] : ~last_r;
		end
		if (ph_r && ad_oe_in != 2'b00)
			mem[addr_r] = ad_oe_in[1] ? ad_drv_in : {8'h00, ad_drv_in[7:0]};
		ph_r <= ale_in;
		last_r <= ad_out;
		cnt_r <= pdt_oe_in ? 0 : cnt_r + 1;
	end
	// memory answers only in the data phase of a read
	always_comb begin
		ad_out = (ph_r && ad_oe_in == 2'b00) ? rd_r : ~last_r;
		if (ad_oe_in[0])
			ad_out[7:0] = ad_drv_in[7:0];
		if (ad_oe_in[1])
			ad_out[15:8] = ad_drv_in[15:8];
	end
	// strap wiring ties the reset indication onto the busy pin
	assign test_busy_out = strap_en_in ? (rst_ind_in | busy_in) : busy_in;
	// capacitor stays charged for a while after release
	assign pdt_out = pdt_oe_in ? pdt_drv_in : (cnt_r < PDT_DLY);
endmodule

//--- test_processor_pin_state_and_reset_logic.sv
// Purpose: self-checking bench of the pin-state and reset logic
// Assumes: inputs change on the rising edge by non-blocking assignment
// Notes: a memory model in the bench predicts every read
module test_processor_pin_state_and_reset_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import pin_logic_pkg::*;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic rst_req_n = 1'b0, busy = 1'b0, nmi = 1'b0, hold = 1'b0, ucs_n = 1'b1, lcs_n = 1'b1;
	logic req = 1'b0, wr = 1'b0, word = 1'b0, wait_x = 1'b0, idle = 1'b0, pd_req = 1'b0;
	logic wake = 1'b0, ack = 1'b0, strap = 1'b0, en = 1'b1;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000;
	logic [3:0] mid = 4'hF, hs = 4'h0;
	logic half, osc, rst_ind, ale, pdt_o, pdt_oe, drv_en, hold_ack, done, stall, nmi_pend;
	logic restart, coproc, all_float_test_mode_o, core_run, busy_lvl, pdt_lvl;
	logic [15:0] ad_o, ad_lvl, rdata;
	logic [1:0] ad_oe;
	logic [3:0] mid_o;
	logic [7:0] nmi_type;
	logic [19:0] fetch;
	int n_mismatch = 0;
	int n_tests = 0;
	int model [int];

	pin_state_ctrl pin_state_ctrl_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .clk_en_in(en),
		.reset_request_n_in(rst_req_n), .test_busy_in(busy_lvl), .nmi_in(nmi),
		.hold_req_in(hold), .upper_memory_select_n_in(ucs_n), .lower_memory_select_n_in(lcs_n),
		.powerdown_exit_timer_pin_in(pdt_lvl), .shared_addr_data_bus_in(ad_lvl),
		.bus_req_in(req), .bus_write_in(wr), .bus_word_in(word), .bus_addr_in(addr),
		.bus_wdata_in(wdata), .wait_exec_in(wait_x), .idle_req_in(idle),
		.powerdown_req_in(pd_req), .wake_in(wake), .nmi_ack_in(ack),
		.mid_range_select_n_in(mid), .coproc_handshake_in(hs), .half_rate_clock_out(half),
		.oscillator_drive_pin_out(osc), .reset_indication_out(rst_ind), .ale_out(ale),
		.shared_addr_data_bus_out(ad_o), .shared_addr_data_bus_oe_out(ad_oe),
		.powerdown_exit_timer_pin_out(pdt_o), .powerdown_exit_timer_pin_oe_out(pdt_oe),
		.mid_range_select_n_out(mid_o), .pins_drive_en_out(drv_en), .hold_ack_out(hold_ack),
		.bus_rdata_out(rdata), .bus_done_out(done), .stall_out(stall),
		.nmi_pending_out(nmi_pend), .nmi_type_out(nmi_type), .restart_fetch_out(restart),
		.fetch_addr_out(fetch), .coproc_mode_out(coproc), .all_float_test_mode_out(all_float_test_mode_o),
		.core_run_out(core_run));

	far_side_model far_side_model_i (.mclk_in(mclk_in), .ad_drv_in(ad_o), .ad_oe_in(ad_oe),
		.ale_in(ale), .rst_ind_in(rst_ind), .strap_en_in(strap), .busy_in(busy),
		.pdt_drv_in(pdt_o), .pdt_oe_in(pdt_oe), .ad_out(ad_lvl), .test_busy_out(busy_lvl),
		.pdt_out(pdt_lvl));

	always #20 mclk_in = ~mclk_in;

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	task automatic clocks();
		logic h, o;
		repeat (4) begin
			h = half;
			o = osc;
			tick(1);
			check(half, !h, "half clock");
			check(osc, !o, "osc drive");
		end
	endtask

	task automatic pin_reset(input logic strap_v, input logic all_float_test_mode_v);
		int k;
		@(posedge mclk_in);
		rst_req_n <= 1'b0;
		strap <= strap_v;
		ucs_n <= !all_float_test_mode_v;
		lcs_n <= !all_float_test_mode_v;
		tick(8);
		check(rst_ind, 1'b1, "reset ind");
		check(ad_oe, 2'b00, "bus float");
		check(mid_o, 4'hF, "selects");
		check(pdt_oe, 1'b0, "timer float");
		clocks();
		@(posedge mclk_in);
		rst_req_n <= 1'b1;
		for (k = 0; k < 20 && restart !== 1'b1; k++) tick(1);
		check(restart, 1'b1, "restart");
		check(fetch, 20'h0FFF0, "fetch addr");
		check(rst_ind, 1'b0, "reset ind off");
		check(coproc, strap_v, "attach mode");
		check(all_float_test_mode_o, all_float_test_mode_v, "float mode");
		check(drv_en, !all_float_test_mode_v, "drive enable");
		@(posedge mclk_in);
		ucs_n <= 1'b1;
		lcs_n <= 1'b1;
		mid <= 4'($urandom);
		hs <= 4'($urandom);
		tick(3);
		check(mid_o, strap_v ? ((mid & 4'h4) | (hs & 4'hB)) : mid, "select mux");
		$display("reset test done strap %0d float %0d", strap_v, all_float_test_mode_v);
	endtask

	task automatic bus_op(input logic w, input logic wd, input logic [15:0] a,
		input logic [15:0] d);
		int k;
		logic [15:0] m;
		m = wd ? 16'hFFFF : 16'h00FF;
		@(posedge mclk_in);
		req <= 1'b1;
		wr <= w;
		word <= wd;
		addr <= a;
		wdata <= d;
		for (k = 0; k < 20 && ale !== 1'b1; k++) tick(1);
		check(ale, 1'b1, "strobe");
		check(ad_o, a, "address");
		check(ad_oe, 2'b11, "address oe");
		@(posedge mclk_in);
		req <= 1'b0;
		#1;
		check(ale, 1'b0, "strobe end");
		check(ad_oe, w ? {wd, 1'b1} : 2'b00, "data oe");
		if (w) begin
			check(ad_o & m, d & m, "write data");
			model[a] = int'(d & m);
		end
		tick(1);
		check(done, 1'b1, "done");
		if (!w) check(rdata, 16'(model[a]) & m, "read data");
	endtask

	initial begin
		int k;
		logic [15:0] a;
		void'($urandom(32'h12336d24));
		repeat (3) @(posedge mclk_in);
		check(rst_ind, 1'b1, "reset ind");
		arst_n_in <= 1'b1;
		pin_reset(1'b0, 1'b0);
		for (k = 0; k < 6; k++) begin
			a = 16'($urandom);
			bus_op(1'b1, k[0], a, 16'($urandom));
			bus_op(1'b0, k[0], a, 16'h0000);
		end
		$display("bus test done");
		for (k = 0; k < 2; k++) begin
			if (k == 1) pin_reset(1'b1, 1'b0);
			@(posedge mclk_in);
			wait_x <= 1'b1;
			busy <= 1'b1;
			tick(6);
			check(stall, 1'b1, "stall");
			@(posedge mclk_in);
			busy <= 1'b0;
			tick(6);
			check(stall, 1'b0, "resume");
			@(posedge mclk_in);
			wait_x <= 1'b0;
		end
		$display("wait test done");
		@(posedge mclk_in);
		nmi <= 1'b1;
		tick(8);
		check(nmi_pend, 1'b1, "nmi latched");
		check(nmi_type, 8'h02, "nmi type");
		@(posedge mclk_in);
		nmi <= 1'b0;
		ack <= 1'b1;
		@(posedge mclk_in);
		ack <= 1'b0;
		tick(6);
		check(nmi_pend, 1'b0, "nmi cleared");
		$display("nmi test done");
		@(posedge mclk_in);
		en <= 1'b0;
		tick(1);
		k = {half, osc};
		tick(3);
		check({half, osc}, k[1:0], "enable freeze");
		@(posedge mclk_in);
		en <= 1'b1;
		idle <= 1'b1;
		req <= 1'b1;
		repeat (4) begin
			tick(1);
			check(ale, 1'b0, "idle no cycle");
		end
		check(rst_ind, 1'b0, "idle reset ind");
		$display("enable and idle test done");
		@(posedge mclk_in);
		req <= 1'b0;
		hold <= 1'b1;
		for (k = 0; k < 20 && hold_ack !== 1'b1; k++) tick(1);
		check(hold_ack, 1'b1, "hold ack");
		check(ad_oe, 2'b00, "hold float");
		check(rst_ind, 1'b0, "hold reset ind");
		check(pdt_oe, 1'b0, "hold timer");
		clocks();
		@(posedge mclk_in);
		hold <= 1'b0;
		idle <= 1'b0;
		tick(8);
		check(hold_ack, 1'b0, "hold drop");
		$display("hold test done");
		a = ad_o;
		@(posedge mclk_in);
		pd_req <= 1'b1;
		tick(6);
		check({pdt_oe, pdt_o}, 2'b11, "timer high");
		check(rst_ind, 1'b0, "pd reset ind");
		check(ad_o, a, "bus retained");
		check(core_run, 1'b0, "core stopped");
		clocks();
		@(posedge mclk_in);
		pd_req <= 1'b0;
		wake <= 1'b1;
		@(posedge mclk_in);
		wake <= 1'b0;
		tick(2);
		check(core_run, 1'b0, "exit wait");
		for (k = 0; k < 40 && core_run !== 1'b1; k++) tick(1);
		check(core_run, 1'b1, "core resumed");
		$display("powerdown test done");
		pin_reset(1'b0, 1'b1);
		clocks();
		pin_reset(1'b0, 1'b0);
		bus_op(1'b0, 1'b1, a, 16'h0000);
		end_of_test();
	end

	initial begin
		#(40ns * 5000);
		n_mismatch++;
		end_of_test();
	end
endmodule
